// >>> src/pie_dev_end.sv
// processor end: interrupt recognition, acknowledge and exception stacking
module pie_dev_end
    import pie_pkg::*;
#(
    parameter int SP_W = PIE_SP_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    pie_link_if.dev link
);
    logic [2:0] smp0;
    logic [2:0] smp1;
    logic [2:0] smp2;
    logic [2:0] lvl;
    logic [2:0] lvl_prev;
    logic nmi_hold;
    logic [15:0] sr;
    logic [15:0] sr_copy;
    logic [31:0] pc;
    logic [SP_W-1:0] isp;
    logic [SP_W-1:0] msp;
    logic [8:0] mem_addr;
    logic cp_active;
    logic [31:0] cp_state;
    logic [7:0] vec;
    logic [2:0] svc_level;
    logic [2:0] idx;
    logic use_msp;
    logic boundary;
    pie_state_t state;
    logic [31:0] stk_mem [2**SP_W];
    logic [31:0] vec_mem [256];

    logic [2:0] mask;
    logic above;
    logic pend_now;
    logic bus_hit;
    logic bus_wr;
    logic [2:0] frame_len;
    logic start;
    logic stk_we;
    logic [SP_W-1:0] stk_addr;
    logic [31:0] stk_data;

    // one frame word; k counts from the deepest word pushed first
    function automatic logic [31:0] frame_word(input logic [2:0] k, input logic [3:0] fmt,
                                               input logic [15:0] sw, input logic [31:0] cnt,
                                               input logic [7:0] v, input logic cp,
                                               input logic [31:0] cpw);
        logic [2:0] j;
        j = cp ? k : k + 3'h1;
        unique case (j)
            3'h0: frame_word = cpw;
            3'h1: frame_word = {16'h0000, fmt, 2'b00, v, 2'b00};
            3'h2: frame_word = cnt;
            default: frame_word = {16'h0000, sw};
        endcase
    endfunction : frame_word

    assign mask = sr[PIE_SR_MASK_LO +: 3];
    assign above = lvl > mask;
    assign pend_now = above | nmi_hold;
    assign bus_hit = (read | write) & ~waitrequest;
    assign bus_wr = write & ~waitrequest;
    assign frame_len = cp_active ? 3'h4 : 3'h3;
    assign start = pend_now & ((state == PIE_ST_IDLE & boundary) | state == PIE_ST_FETCH);

    // third stage only debounces; the first flop feeds nothing but the second
    always_ff @(negedge clock) begin
        if (rst) begin
            smp0 <= PIE_LVL_NONE;
            smp1 <= PIE_LVL_NONE;
            smp2 <= PIE_LVL_NONE;
            lvl <= PIE_LVL_NONE;
        end else if (clk_en) begin
            smp0 <= ~link.irq_level_n;
            smp1 <= smp0;
            smp2 <= smp1;
            if (smp1 == smp2) begin
                lvl <= smp2;
            end
        end
    end

    // level seven is caught on its rising transition; a new edge beats the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            lvl_prev <= PIE_LVL_NONE;
            nmi_hold <= 1'b0;
            link.irq_pending_out <= 1'b0;
        end else if (clk_en) begin
            lvl_prev <= lvl;
            if (lvl == PIE_LVL_NMI && lvl_prev != PIE_LVL_NMI) begin
                nmi_hold <= 1'b1;
            end else if (start && svc_level_next() == PIE_LVL_NMI) begin
                nmi_hold <= 1'b0;
            end
            link.irq_pending_out <= pend_now & ~start;
        end
    end

    function automatic logic [2:0] svc_level_next();
        svc_level_next = nmi_hold ? PIE_LVL_NMI : lvl;
    endfunction : svc_level_next

    // exception sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= PIE_ST_IDLE;
            sr <= PIE_SR_RESET;
            sr_copy <= PIE_SR_RESET;
            pc <= PIE_PC_RESET;
            isp <= PIE_ISP_RESET;
            msp <= PIE_MSP_RESET;
            vec <= PIE_VEC_RESET;
            svc_level <= PIE_LVL_NONE;
            idx <= 3'h0;
            use_msp <= 1'b0;
            link.iack <= 1'b0;
            link.iack_level <= PIE_LVL_NONE;
        end else if (clk_en) begin
            if (bus_wr && address == PIE_REG_STATUS_WORD) begin
                sr <= writedata[15:0];
            end
            if (bus_wr && address == PIE_REG_PC) begin
                pc <= writedata;
            end
            if (bus_wr && address == PIE_REG_ISP) begin
                isp <= writedata[SP_W-1:0];
            end
            if (bus_wr && address == PIE_REG_MSP) begin
                msp <= writedata[SP_W-1:0];
            end
            if (start) begin
                sr_copy <= sr;
                sr[PIE_SR_S] <= 1'b1;
                sr[PIE_SR_T1] <= 1'b0;
                sr[PIE_SR_T0] <= 1'b0;
                sr[PIE_SR_MASK_LO +: 3] <= svc_level_next();
                svc_level <= svc_level_next();
                use_msp <= sr[PIE_SR_M];
                link.iack <= 1'b1;
                link.iack_level <= svc_level_next();
                // a restart from the fetch still owes the first handler its entry address
                if (state == PIE_ST_FETCH) begin
                    pc <= vec_mem[vec];
                end
                state <= PIE_ST_ACK;
            end else begin
                unique case (state)
                    PIE_ST_IDLE: begin
                    end
                    PIE_ST_ACK: begin
                        if (link.bus_error_in) begin
                            vec <= PIE_VEC_SPURIOUS;
                        end else if (link.autovector_req) begin
                            vec <= PIE_VEC_AUTO_BASE + {5'h00, svc_level};
                        end else begin
                            vec <= link.vector_data;
                        end
                        if (link.bus_error_in | link.autovector_req | link.vector_valid) begin
                            link.iack <= 1'b0;
                            link.iack_level <= PIE_LVL_NONE;
                            idx <= 3'h0;
                            state <= PIE_ST_PUSH;
                        end
                    end
                    PIE_ST_PUSH: begin
                        idx <= idx + 3'h1;
                        if (idx == frame_len - 3'h1) begin
                            idx <= 3'h0;
                            if (use_msp) begin
                                msp <= msp - SP_W'(frame_len);
                                sr[PIE_SR_M] <= 1'b0;
                                state <= PIE_ST_THROW;
                            end else begin
                                isp <= isp - SP_W'(frame_len);
                                state <= PIE_ST_FETCH;
                            end
                        end
                    end
                    PIE_ST_THROW: begin
                        idx <= idx + 3'h1;
                        if (idx == 3'h2) begin
                            idx <= 3'h0;
                            isp <= isp - SP_W'(3);
                            state <= PIE_ST_FETCH;
                        end
                    end
                    PIE_ST_FETCH: begin
                        pc <= vec_mem[vec];
                        state <= PIE_ST_IDLE;
                    end
                    default: state <= PIE_ST_IDLE;
                endcase
            end
        end
    end

    // stack writes come from the sequencer while it pushes, and from software in any other state
    always_comb begin
        stk_we = 1'b0;
        stk_addr = isp;
        stk_data = 32'h0000_0000;
        if (state == PIE_ST_PUSH) begin
            stk_we = 1'b1;
            stk_addr = (use_msp ? msp : isp) - SP_W'(1) - SP_W'(idx);
            stk_data = frame_word(idx, cp_active ? PIE_FMT_COPROC : PIE_FMT_NORMAL,
                                  sr_copy, pc, vec, cp_active, cp_state);
        end else if (state == PIE_ST_THROW) begin
            stk_we = 1'b1;
            stk_addr = isp - SP_W'(1) - SP_W'(idx);
            stk_data = frame_word(idx, PIE_FMT_THROW, sr_copy | (16'h0001 << PIE_SR_S),
                                  pc, vec, 1'b0, cp_state);
        end else if (bus_wr && address == PIE_REG_MEM_DATA && !mem_addr[PIE_MEM_SEL_VEC]) begin
            stk_we = 1'b1;
            stk_addr = mem_addr[SP_W-1:0];
            stk_data = writedata;
        end
    end

    always_ff @(posedge clock) begin
        if (clk_en && stk_we) begin
            stk_mem[stk_addr] <= stk_data;
        end
        if (clk_en && bus_wr && address == PIE_REG_MEM_DATA && mem_addr[PIE_MEM_SEL_VEC]) begin
            vec_mem[mem_addr[7:0]] <= writedata;
        end
    end

    // software-side control registers
    always_ff @(posedge clock) begin
        if (rst) begin
            boundary <= 1'b0;
            cp_active <= 1'b0;
            cp_state <= 32'h0000_0000;
            mem_addr <= 9'h000;
        end else if (clk_en) begin
            boundary <= bus_wr && address == PIE_REG_CTRL && writedata[PIE_CTRL_BOUNDARY];
            if (bus_wr && address == PIE_REG_CTRL) begin
                cp_active <= writedata[PIE_CTRL_CP_ACTIVE];
            end
            if (bus_wr && address == PIE_REG_CP_STATE) begin
                cp_state <= writedata;
            end
            if (bus_wr && address == PIE_REG_MEM_ADDR) begin
                mem_addr <= writedata[8:0];
            end
        end
    end

    // avalon slave: one wait cycle per access, unmapped reads give zero
    always_ff @(posedge clock) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else if (clk_en) begin
            waitrequest <= ~((read | write) & waitrequest);
            if (read && waitrequest) begin
                unique case (address)
                    PIE_REG_STATUS_WORD: readdata <= {16'h0000, sr};
                    PIE_REG_PC: readdata <= pc;
                    PIE_REG_CTRL: readdata <= {30'h0000_0000, cp_active, 1'b0};
                    PIE_REG_STATE: readdata <= {16'h0000, vec, 1'b0, lvl, 2'b00,
                                                state != PIE_ST_IDLE, link.irq_pending_out};
                    PIE_REG_ISP: readdata <= 32'(isp);
                    PIE_REG_MSP: readdata <= 32'(msp);
                    PIE_REG_MEM_ADDR: readdata <= {23'h00_0000, mem_addr};
                    PIE_REG_MEM_DATA: readdata <= mem_addr[PIE_MEM_SEL_VEC] ?
                        vec_mem[mem_addr[7:0]] : stk_mem[mem_addr[SP_W-1:0]];
                    PIE_REG_CP_STATE: readdata <= cp_state;
                    default: readdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : pie_dev_end

// >>> shared/pie_pkg.sv
// constants and types shared by both ends of the prioritized interrupt link
package pie_pkg;
    localparam int PIE_LVL_W = 3;
    localparam logic [2:0] PIE_LVL_NONE = 3'h0;
    localparam logic [2:0] PIE_LVL_NMI = 3'h7;
    // vector numbers
    localparam logic [7:0] PIE_VEC_SPURIOUS = 8'h18;
    localparam logic [7:0] PIE_VEC_AUTO_BASE = 8'h18;
    localparam logic [7:0] PIE_VEC_UNINIT = 8'h0F;
    // frame formats
    localparam logic [3:0] PIE_FMT_NORMAL = 4'h0;
    localparam logic [3:0] PIE_FMT_THROW = 4'h1;
    localparam logic [3:0] PIE_FMT_COPROC = 4'h9;
    // status word fields and reset value
    localparam int PIE_SR_T1 = 15;
    localparam int PIE_SR_T0 = 14;
    localparam int PIE_SR_S = 13;
    localparam int PIE_SR_M = 12;
    localparam int PIE_SR_MASK_LO = 8;
    localparam logic [15:0] PIE_SR_RESET = 16'h2700;
    // register byte offsets on the avalon slave
    localparam logic [5:0] PIE_REG_STATUS_WORD = 6'h00;
    localparam logic [5:0] PIE_REG_PC = 6'h04;
    localparam logic [5:0] PIE_REG_CTRL = 6'h08;
    localparam logic [5:0] PIE_REG_STATE = 6'h0C;
    localparam logic [5:0] PIE_REG_ISP = 6'h10;
    localparam logic [5:0] PIE_REG_MSP = 6'h14;
    localparam logic [5:0] PIE_REG_MEM_ADDR = 6'h18;
    localparam logic [5:0] PIE_REG_MEM_DATA = 6'h1C;
    localparam logic [5:0] PIE_REG_CP_STATE = 6'h20;
    // control bits, and the vector-memory select bit of the memory address
    localparam int PIE_CTRL_BOUNDARY = 0;
    localparam int PIE_CTRL_CP_ACTIVE = 1;
    localparam int PIE_MEM_SEL_VEC = 8;
    // sizes and reset values
    localparam int PIE_SP_W = 6;
    localparam logic [31:0] PIE_PC_RESET = 32'h0000_0000;
    localparam logic [5:0] PIE_ISP_RESET = 6'h00;
    localparam logic [5:0] PIE_MSP_RESET = 6'h20;
    localparam logic [7:0] PIE_VEC_RESET = 8'h00;
    typedef enum logic [2:0] {
        PIE_ST_IDLE,
        PIE_ST_ACK,
        PIE_ST_PUSH,
        PIE_ST_THROW,
        PIE_ST_FETCH
    } pie_state_t;
endpackage : pie_pkg

// >>> shared/pie_link_if.sv
// interrupt request and acknowledge signals between processor and requester
interface pie_link_if;
    logic [2:0] irq_level_n;
    logic irq_pending_out;
    logic iack;
    logic [2:0] iack_level;
    logic vector_valid;
    logic [7:0] vector_data;
    logic autovector_req;
    logic bus_error_in;
    modport dev (
        input irq_level_n,
        output irq_pending_out,
        output iack,
        output iack_level,
        input vector_valid,
        input vector_data,
        input autovector_req,
        input bus_error_in
    );
    modport req (
        output irq_level_n,
        input irq_pending_out,
        input iack,
        input iack_level,
        output vector_valid,
        output vector_data,
        output autovector_req,
        output bus_error_in
    );
endinterface : pie_link_if

// >>> src/pie_req_end.sv
// requester end: holds a prioritized request and answers the acknowledge cycle
module pie_req_end
    import pie_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic raise,
    input wire logic [2:0] raise_level,
    input wire logic use_autovector,
    input wire logic vector_set,
    input wire logic [7:0] vector_num,
    output logic busy,
    output logic serviced,
    pie_link_if.req link
);
    logic [2:0] held;
    logic [7:0] own_vec;
    logic vec_ready;
    logic acked;
    logic match;

    assign match = link.iack && !acked && held != PIE_LVL_NONE && link.iack_level == held;

    // level stays put until our own acknowledge; raises while a level is held are dropped
    always_ff @(posedge clock) begin
        if (rst) begin
            held <= PIE_LVL_NONE;
            link.irq_level_n <= ~PIE_LVL_NONE;
            busy <= 1'b0;
            serviced <= 1'b0;
        end else if (clk_en) begin
            serviced <= 1'b0;
            if (match) begin
                held <= PIE_LVL_NONE;
                link.irq_level_n <= ~PIE_LVL_NONE;
                busy <= 1'b0;
                serviced <= 1'b1;
            end else if (raise && held == PIE_LVL_NONE) begin
                held <= raise_level;
                link.irq_level_n <= ~raise_level;
                busy <= raise_level != PIE_LVL_NONE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            own_vec <= PIE_VEC_UNINIT;
            vec_ready <= 1'b0;
        end else if (clk_en && vector_set) begin
            own_vec <= vector_num;
            vec_ready <= 1'b1;
        end
    end

    // vector answers last one cycle, a bus error two; a foreign level gets no answer from this end unless nothing is held
    always_ff @(posedge clock) begin
        if (rst) begin
            acked <= 1'b0;
            link.vector_valid <= 1'b0;
            link.vector_data <= 8'h00;
            link.autovector_req <= 1'b0;
            link.bus_error_in <= 1'b0;
        end else if (clk_en) begin
            acked <= link.iack & (acked | match);
            link.vector_valid <= match & ~use_autovector;
            link.autovector_req <= match & use_autovector;
            link.vector_data <= vec_ready ? own_vec : PIE_VEC_UNINIT;
            link.bus_error_in <= link.iack && !acked && !match && held == PIE_LVL_NONE;
        end
    end
endmodule : pie_req_end

// >>> tb/pie_link_assertions.sv
// concurrent checks on the request and acknowledge link between the two ends
module pie_link_assertions
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] irq_level_n,
    input wire logic irq_pending_out,
    input wire logic iack,
    input wire logic [2:0] iack_level,
    input wire logic vector_valid,
    input wire logic autovector_req,
    input wire logic bus_error_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ans;
    // any of the three ways a requester can close an acknowledge cycle
    assign ans = vector_valid | autovector_req | bus_error_in;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_RESET_IDLE: assert property (disable iff (1'b0)
        rst |=> irq_level_n == 3'b111 && !irq_pending_out && !iack)
        else $error("link not idle after reset");
    AST_PEND_SYNC: assert property ($rose(irq_pending_out) |-> irq_level_n != 3'b111
        && $past(irq_level_n) == irq_level_n && $past(irq_level_n, 2) == irq_level_n)
        else $error("pending raised without a settled level");
    AST_PEND_LEVEL: assert property (irq_pending_out && !iack |-> irq_level_n != 3'b111)
        else $error("pending while level is zero");
    AST_IACK_PEND: assert property ($rose(iack) |-> $past(irq_pending_out))
        else $error("acknowledge without pending");
    AST_IACK_DROP: assert property ($rose(iack) |-> !irq_pending_out)
        else $error("pending still high in first acknowledge state");
    AST_IACK_LEVEL: assert property ($rose(iack) |-> iack_level == ~irq_level_n)
        else $error("acknowledged level differs from request");
    AST_IACK_HOLD: assert property (iack && !ans |=> iack && $stable(iack_level))
        else $error("acknowledge dropped before an answer");
    AST_ANS_TIME: assert property ($rose(iack) |=> ans)
        else $error("requester did not answer one cycle after acknowledge");
    AST_ANS_END: assert property (ans && iack |=> !iack)
        else $error("acknowledge not closed after answer");
    AST_ANS_IN_ACK: assert property (ans |-> iack)
        else $error("answer outside an acknowledge cycle");
endmodule : pie_link_assertions

// >>> tb/tb.sv
// self-checking bench: both link ends joined, orders given over the avalon slave
module tb
    import pie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, clk_en, read, write, raise, use_autovector, vector_set, vec_init;
    logic waitrequest, busy, serviced;
    logic [5:0] address;
    logic [31:0] writedata, readdata, seed, q, isp0, msp0;
    logic [2:0] raise_level;
    logic [7:0] vector_num;
    int err_count, checked;
    logic cp_mode;
    logic [31:0] pc_last;

    pie_link_if link();
    pie_dev_end i_pie_dev_end (.clock(clock), .rst(rst), .clk_en(clk_en), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .link(link));
    pie_req_end i_pie_req_end (.clock(clock), .rst(rst), .clk_en(clk_en), .raise(raise),
        .raise_level(raise_level), .use_autovector(use_autovector), .vector_set(vector_set),
        .vector_num(vector_num), .busy(busy), .serviced(serviced), .link(link));
    pie_link_assertions i_pie_link_assertions (.clock(clock), .rst(rst),
        .irq_level_n(link.irq_level_n), .irq_pending_out(link.irq_pending_out),
        .iack(link.iack), .iack_level(link.iack_level), .vector_valid(link.vector_valid),
        .autovector_req(link.autovector_req), .bus_error_in(link.bus_error_in));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic test_done();
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // one avalon transfer; a free edge first so a release never meets a new request
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
            output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge clock);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        if (waitrequest !== 1'b0) begin
            err_count++;
        end
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0000_0000, d);
    endtask : rd

    // one stack word read back through the software window
    task automatic peek(input logic [31:0] idx, output logic [31:0] d);
        wr(PIE_REG_MEM_ADDR, idx & 32'h0000_003F);
        rd(PIE_REG_MEM_DATA, d);
    endtask : peek

    // model of the vector the processor ends up with
    function automatic logic [7:0] exp_vec(input int lvl, input logic av);
        if (av) begin
            return PIE_VEC_AUTO_BASE + 8'(lvl);
        end
        return vec_init ? vector_num : PIE_VEC_UNINIT;
    endfunction : exp_vec

    task automatic intr(input int lvl, input logic av, input int mask, input logic mbit);
        logic [7:0] v;
        logic [31:0] sw, entry;
        logic [31:0] saved, fl, sp, cpw;
        int n;
        v = exp_vec(lvl, av);
        sw = 32'h0000_2000 | (32'(mbit) << 12);
        entry = rnd();
        cpw = rnd();
        fl = cp_mode ? 32'h0000_0004 : 32'h0000_0003;
        saved = sw | (32'(mask) << 8);
        wr(PIE_REG_STATUS_WORD, sw | (32'(mask) << 8));
        rd(PIE_REG_ISP, isp0);
        rd(PIE_REG_MSP, msp0);
        wr(PIE_REG_MEM_ADDR, 32'h0000_0100 | 32'(v));
        wr(PIE_REG_MEM_DATA, entry);
        wr(PIE_REG_CP_STATE, cpw);
        @(posedge clock);
        raise <= 1'b1;
        raise_level <= 3'(lvl);
        use_autovector <= av;
        @(posedge clock);
        raise <= 1'b0;
        if (lvl <= mask && lvl != 7) begin
            repeat (20) @(posedge clock);
            check(32'(link.irq_pending_out), 32'h0000_0000);
            wr(PIE_REG_STATUS_WORD, sw);
            saved = sw;
        end
        n = 0;
        while (link.irq_pending_out !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        check(32'(link.irq_pending_out), 32'h0000_0001);
        check(32'(busy), 32'h0000_0001);
        wr(PIE_REG_CTRL, 32'h0000_0001 | (32'(cp_mode) << 1));
        n = 0;
        while (serviced !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        check(32'(serviced), 32'h0000_0001);
        check(32'(busy), 32'h0000_0000);
        q = 32'h0000_0002;
        n = 0;
        while (q[1] !== 1'b0 && n < 50) begin
            rd(PIE_REG_STATE, q);
            n++;
        end
        check({24'h0, q[15:8]}, {24'h0, v});
        rd(PIE_REG_STATUS_WORD, q);
        check({16'h0, q[15:0]}, 32'h0000_2000 | (32'(lvl) << 8));
        rd(PIE_REG_PC, q);
        check(q, entry);
        rd(PIE_REG_ISP, q);
        check(q, (isp0 - (mbit ? 32'h0000_0003 : fl)) & 32'h0000_003F);
        rd(PIE_REG_MSP, q);
        check(q, mbit ? ((msp0 - fl) & 32'h0000_003F) : msp0);
        // frame from the new top: status copy, counter, format word, coprocessor word
        sp = (mbit ? msp0 : isp0) - fl;
        peek(sp, q);
        check(q, {16'h0000, saved[15:0]});
        peek(sp + 32'h0000_0001, q);
        check(q, pc_last);
        peek(sp + 32'h0000_0002, q);
        check(q, {16'h0000, cp_mode ? PIE_FMT_COPROC : PIE_FMT_NORMAL, 2'b00, v, 2'b00});
        if (cp_mode) begin
            peek(sp + 32'h0000_0003, q);
            check(q, cpw);
        end
        if (mbit) begin
            peek(isp0 - 32'h0000_0003, q);
            check(q, {16'h0000, saved[15:0] | 16'h2000});
            peek(isp0 - 32'h0000_0002, q);
            check(q, pc_last);
            peek(isp0 - 32'h0000_0001, q);
            check(q, {16'h0000, PIE_FMT_THROW, 2'b00, v, 2'b00});
        end
        pc_last = entry;
    endtask : intr

    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        test_done();
    end

    initial begin
        seed = 32'h0000_0039;
        rst = 1'b1;
        clk_en = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0000_0000;
        raise = 1'b0;
        raise_level = 3'h0;
        use_autovector = 1'b0;
        vector_set = 1'b0;
        vector_num = 8'h00;
        vec_init = 1'b0;
        cp_mode = 1'b0;
        pc_last = PIE_PC_RESET;
        err_count = 0;
        checked = 0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd(PIE_REG_STATUS_WORD, q);
        check({16'h0, q[15:0]}, {16'h0, PIE_SR_RESET});
        rd(PIE_REG_STATE, q);
        check(q, 32'h0000_0000);
        rd(6'h24, q);
        check(q, 32'h0000_0000);
        intr(3, 1'b0, 0, 1'b0); // vector never loaded
        @(posedge clock);
        vector_num <= 8'(rnd());
        vector_set <= 1'b1;
        @(posedge clock);
        vector_set <= 1'b0;
        vec_init = 1'b1;
        intr(2, 1'b0, 7, 1'b0); // held under the mask, then unmasked
        for (int l = 1; l < 8; l++) begin
            intr(l, 1'b1, l - 1, 1'(l));
        end
        cp_mode = 1'b1; // coprocessor frames, plain and with the master stack
        intr(5, 1'b0, 2, 1'b0);
        intr(4, 1'b1, 0, 1'b1);
        cp_mode = 1'b0;
        intr(7, 1'b0, 7, 1'b0);
        intr(7, 1'b0, 7, 1'b0); // second rise to seven with mask at seven
        test_done();
    end
endmodule : tb
